// ===== design/sdcp_top.sv
// command layer of a four bank synchronous dram, seen from the memory side
// assumes the controller drives pins on the same clock edge, so pins are not resynchronised
// the data pins are split into input, output and per byte lane output enable
`timescale 1ns/1ps
`default_nettype none
`include "sdcp_map.svh"
module sdcp_top
  import sdcp_pkg::*;
#(
  parameter int ROW_W = 12, // row address bits
  parameter int COL_W = 8, // column address bits
  parameter int CAS_LAT = 2, // read latency in clocks, at least one
  parameter int BURST_LEN = 4, // beats per burst, zero for a continuous page burst
  parameter bit AUTOMOTIVE = 1'b0 // variant without self refresh
)
(
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RSTN_I,
  // command pins
  input wire logic CKE_I,
  input wire logic CS_N_I,
  input wire logic RAS_N_I,
  input wire logic CAS_N_I,
  input wire logic WE_N_I,
  input wire logic [`SDCP_BANK_W-1:0] BA_I,
  input wire logic [`SDCP_ADDR_W-1:0] ADDR_I,
  input wire logic [`SDCP_LANES-1:0] DQM_I,
  // data pins
  input wire logic [`SDCP_DQ_W-1:0] DQ_I,
  output logic [`SDCP_DQ_W-1:0] DQ_O,
  output logic [`SDCP_LANES-1:0] DQ_OE_O,
  // status
  output logic [`SDCP_ADDR_W-1:0] MODE_O,
  output logic [`SDCP_BANKS-1:0] BANK_OPEN_O,
  output logic [ROW_W-1:0] REFRESH_ROW_O,
  output logic SELF_REF_O,
  output logic BURST_ACT_O
);
  // derived sizes; a page burst needs one more bit of beat count than a column
  localparam int AW = `SDCP_BANK_W + ROW_W + COL_W; // word address width
  localparam int MEM_WORDS = 2 ** AW; // storage depth
  localparam int LEFT_W = COL_W + 1; // room for a burst of a whole page
  localparam bit PAGE = (BURST_LEN == 0); // burst runs until stopped
  localparam logic [LEFT_W-1:0] BL_LEFT = LEFT_W'(BURST_LEN - 1); // beats after the first
  // internal refresh interval in self refresh, rounded down so no row is late
  localparam int SR_CYC = `SDCP_SELF_REF_NS * `SDCP_CLK_KHZ / 1000000;
  localparam int SR_W = $clog2(SR_CYC + 1);
  localparam logic [SR_W-1:0] SR_LAST = SR_W'(SR_CYC - 1);

  // storage, not reset: contents are undefined after power up anyway
  logic [`SDCP_DQ_W-1:0] mem [MEM_WORDS];

  // command decode
  sdcp_ctl_t ctl; // sampled command pins
  sdcp_cmd_t cmd; // decoded command
  logic run; // device may take commands this edge
  logic ap_flag; // precharge flag bit of the address
  logic is_act;
  logic is_rd;
  logic is_wr;
  logic is_bst;
  logic is_pre;
  logic is_ref;
  logic is_mrs;
  logic sr_enter; // self refresh entry
  logic sr_tick; // internal refresh tick in self refresh

  // device state
  sdcp_state_t state_r;
  sdcp_state_t state_nxt;
  logic self_r; // copy of the state for the pin
  logic [`SDCP_ADDR_W-1:0] mode_r; // loaded mode value
  logic [ROW_W-1:0] ref_row_r; // shared refresh row counter
  logic [ROW_W-1:0] ref_row_nxt;
  logic [SR_W-1:0] sr_cnt_r; // self refresh interval counter

  // banks
  logic [`SDCP_BANKS-1:0] act_vec; // activate per bank
  logic [`SDCP_BANKS-1:0] pre_vec; // close per bank
  logic [`SDCP_BANKS-1:0] bank_open; // open flags
  logic [ROW_W-1:0] bank_row [`SDCP_BANKS]; // open rows

  // burst engine
  logic burst_act_r; // beats still to come
  logic burst_wr_r; // running burst is a write
  logic burst_ap_r; // running burst closes its row at the end
  logic [`SDCP_BANK_W-1:0] burst_bank_r;
  logic [COL_W-1:0] burst_col_r; // column of the next beat
  logic [LEFT_W-1:0] burst_left_r; // beats after the next one
  logic new_rw; // read or write taken this edge
  logic pre_hits; // precharge lands on the running burst's bank
  logic beat; // a data beat happens this edge
  logic beat_ok; // beat into an open row
  logic last_beat; // beat ends a fixed length burst
  logic wr_cur;
  logic ap_cur;
  logic ap_end; // auto close at a natural end
  logic ap_intr; // auto close of a burst cut by a new access
  logic [`SDCP_BANK_W-1:0] bank_cur;
  logic [COL_W-1:0] col_cur;
  logic [LEFT_W-1:0] left_cur;
  logic burst_act_nxt;
  logic [AW-1:0] mem_addr;
  logic rd_now;
  logic wr_now;

  // read path
  sdcp_rd_t rd_in [CAS_LAT]; // next value of each latency stage
  sdcp_rd_t rd_pipe_r [CAS_LAT]; // latency stages, last one drives the pins
  logic [`SDCP_LANES-1:0] dqm_d_r; // mask from the previous edge
  logic [`SDCP_LANES-1:0] dq_oe_r;

  // decode; a deselect or a selected no-op raises none of the strobes
  assign ctl = {CS_N_I, RAS_N_I, CAS_N_I, WE_N_I};
  assign cmd = sdcp_decode(ctl);
  assign run = (state_r == ST_NORMAL) && CKE_I;
  // one flag bit: auto close on an access, all banks on a precharge
  assign ap_flag = ADDR_I[`SDCP_AP_BIT];
  assign is_act = run && (cmd == CMD_ACT);
  assign is_rd = run && (cmd == CMD_READ);
  assign is_wr = run && (cmd == CMD_WRITE);
  assign is_bst = run && (cmd == CMD_BST);
  assign is_pre = run && (cmd == CMD_PRE);
  assign is_ref = run && (cmd == CMD_REF);
  assign is_mrs = run && (cmd == CMD_MRS);
  // the refresh pattern with the clock gate low; the automotive part never enters
  assign sr_enter = (state_r == ST_NORMAL) && !CKE_I && (cmd == CMD_REF)
                    && !AUTOMOTIVE;

  // power state: leave self refresh as soon as the clock gate is seen high
  assign state_nxt = sr_enter ? ST_SELF :
                     ((state_r == ST_SELF) && CKE_I) ? ST_NORMAL : state_r;

  // internal refresh timer only runs in self refresh
  assign sr_tick = (state_r == ST_SELF) && (sr_cnt_r == SR_LAST);
  // address pins are never looked at for a refresh
  assign ref_row_nxt = (is_ref || sr_tick) ? ref_row_r + ROW_W'(1) : ref_row_r;

  // burst beat selection: a new read or write replaces any running burst
  assign new_rw = is_rd || is_wr;
  assign pre_hits = is_pre && burst_act_r && (ap_flag || (BA_I == burst_bank_r));
  // terminate or a precharge on the burst's bank stops it; a suspended clock holds it
  assign beat = new_rw || (burst_act_r && run && !is_bst && !pre_hits);
  assign bank_cur = new_rw ? BA_I : burst_bank_r;
  assign col_cur = new_rw ? ADDR_I[COL_W-1:0] : burst_col_r;
  assign wr_cur = new_rw ? is_wr : burst_wr_r;
  assign ap_cur = new_rw ? ap_flag : burst_ap_r;
  assign left_cur = new_rw ? BL_LEFT : burst_left_r;
  assign last_beat = beat && !PAGE && (left_cur == '0);
  // limitation: a beat into a closed bank is dropped, yet the burst still counts on
  assign beat_ok = beat && bank_open[bank_cur];
  // word address: bank, that bank's open row, then the column of this beat
  assign mem_addr = {bank_cur, bank_row[bank_cur], col_cur};
  assign rd_now = beat_ok && !wr_cur;
  assign wr_now = beat_ok && wr_cur;
  // a plain clock gate freezes the burst; entering self refresh drops it
  assign burst_act_nxt = beat ? !last_beat : (burst_act_r && !run && (state_r == ST_NORMAL));
  // the row closes when its burst ends, or when a new access cuts it short
  assign ap_end = last_beat && ap_cur;
  assign ap_intr = new_rw && burst_act_r && burst_ap_r;

  // per bank strobes
  // each bank keeps its own row, so rows in different banks stay open together
  for (genvar b = 0; b < `SDCP_BANKS; b++)
  begin : g_bank
    assign act_vec[b] = is_act && (BA_I == `SDCP_BANK_W'(b));
    // flag high closes every bank and the bank select is not looked at
    assign pre_vec[b] = (is_pre && (ap_flag || (BA_I == `SDCP_BANK_W'(b))))
                        || (ap_end && (bank_cur == `SDCP_BANK_W'(b)))
                        || (ap_intr && (burst_bank_r == `SDCP_BANK_W'(b)));
    sdcp_bank #(
      .ROW_W(ROW_W)
    ) u_bank (
      .clk_i(CLK_SYS_I),
      .rstn_i(RSTN_I),
      .act_i(act_vec[b]),
      .pre_i(pre_vec[b]),
      .row_i(ADDR_I[ROW_W-1:0]),
      .open_o(bank_open[b]),
      .row_o(bank_row[b])
    );
  end

  // read latency stages: stage zero takes the fetched word
  // the array is read without a register, so stage zero is the first flop of the latency
  assign rd_in[0] = '{valid: rd_now, data: mem[mem_addr]};
  for (genvar s = 1; s < CAS_LAT; s++)
  begin : g_rd
    assign rd_in[s] = rd_pipe_r[s-1];
  end

  // state, mode and refresh counter
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RSTN_I)
    begin
      state_r <= ST_NORMAL;
      self_r <= 1'b0;
      mode_r <= `SDCP_MODE_RST;
      ref_row_r <= '0;
      sr_cnt_r <= '0;
    end
    else
    begin
      // the pin copy follows the next state, so it stays a plain flop output
      state_r <= state_nxt;
      self_r <= (state_nxt == ST_SELF);
      // auto refresh and self refresh share this one counter
      ref_row_r <= ref_row_nxt;
      if (is_mrs)
      begin
        mode_r <= ADDR_I;
      end
      // counter restarts on every entry and wraps on each tick
      if ((state_r != ST_SELF) || sr_tick)
      begin
        sr_cnt_r <= '0;
      end
      else
      begin
        sr_cnt_r <= sr_cnt_r + SR_W'(1);
      end
    end
  end

  // burst bookkeeping, all but the active flag only moved by a beat
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RSTN_I)
    begin
      burst_act_r <= 1'b0;
      burst_wr_r <= 1'b0;
      burst_ap_r <= 1'b0;
      burst_bank_r <= '0;
      burst_col_r <= '0;
      burst_left_r <= '0;
    end
    else
    begin
      burst_act_r <= burst_act_nxt;
      // between beats the bookkeeping holds, so a gated clock can resume the burst
      if (beat)
      begin
        burst_wr_r <= wr_cur;
        burst_ap_r <= ap_cur;
        burst_bank_r <= bank_cur;
        burst_col_r <= col_cur + COL_W'(1); // wraps within the page
        burst_left_r <= left_cur - LEFT_W'(1);
      end
    end
  end

  // byte masked store; a masked lane keeps its old contents
  always_ff @(posedge CLK_SYS_I)
  begin
    for (int l = 0; l < `SDCP_LANES; l++)
    begin
      // nothing is stored during reset, even if the pins show a write
      if (RSTN_I && wr_now && !DQM_I[l])
      begin
        mem[mem_addr][l*`SDCP_LANE_W +: `SDCP_LANE_W] <=
          DQ_I[l*`SDCP_LANE_W +: `SDCP_LANE_W];
      end
    end
  end

  // read pipe and lane enables; the enable flop uses last edge's mask,
  // so a mask taken at edge n acts on the word sampled at edge n+2
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RSTN_I)
    begin
      for (int s = 0; s < CAS_LAT; s++)
      begin
        rd_pipe_r[s] <= '0;
      end
      // all lanes masked after reset, so no stale word can drive the pins
      dqm_d_r <= '1;
      dq_oe_r <= '0;
    end
    else
    begin
      for (int s = 0; s < CAS_LAT; s++)
      begin
        rd_pipe_r[s] <= rd_in[s];
      end
      dqm_d_r <= DQM_I;
      dq_oe_r <= {`SDCP_LANES{rd_in[CAS_LAT-1].valid}} & ~dqm_d_r;
    end
  end

  // outputs, all from flops
  assign DQ_O = rd_pipe_r[CAS_LAT-1].data;
  assign DQ_OE_O = dq_oe_r;
  assign MODE_O = mode_r;
  assign BANK_OPEN_O = bank_open;
  assign REFRESH_ROW_O = ref_row_r;
  assign SELF_REF_O = self_r;
  assign BURST_ACT_O = burst_act_r;
endmodule // sdcp_top
`default_nettype wire

// ===== design/sdcp_map.svh
// named constants of the synchronous dram command layer: pin patterns, widths, times
// assumes a single 20 MHz system clock that also clocks the command pins
`ifndef SDCP_MAP_SVH
`define SDCP_MAP_SVH
// {row strobe, column strobe, write strobe} patterns, active low
`define SDCP_PAT_NOP 3'b111
`define SDCP_PAT_ACT 3'b011
`define SDCP_PAT_READ 3'b101
`define SDCP_PAT_WRITE 3'b100
`define SDCP_PAT_BST 3'b110
`define SDCP_PAT_PRE 3'b010
`define SDCP_PAT_REF 3'b001
`define SDCP_PAT_MRS 3'b000
// address and data geometry
`define SDCP_AP_BIT 10
`define SDCP_ADDR_W 12
`define SDCP_BANK_W 2
`define SDCP_BANKS 4
`define SDCP_DQ_W 32
`define SDCP_LANES 4
`define SDCP_LANE_W 8
// reset values
`define SDCP_MODE_RST 12'h000
// clock rate and internal self refresh interval
`define SDCP_CLK_KHZ 20000
`define SDCP_SELF_REF_NS 15625
`endif

// ===== design/sdcp_pkg.sv
// types and the command decoder of the dram command layer
// assumes sdcp_map.svh is on the include path
`include "sdcp_map.svh"
package sdcp_pkg;
  // decoded command of one clock edge
  typedef enum logic [3:0] {
    CMD_DESEL,
    CMD_NOP,
    CMD_ACT,
    CMD_READ,
    CMD_WRITE,
    CMD_BST,
    CMD_PRE,
    CMD_REF,
    CMD_MRS
  } sdcp_cmd_t;
  // device power state
  typedef enum logic {
    ST_NORMAL,
    ST_SELF
  } sdcp_state_t;
  // command pins as sampled
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } sdcp_ctl_t;
  // one stage of the read latency pipe
  typedef struct packed {
    logic valid;
    logic [`SDCP_DQ_W-1:0] data;
  } sdcp_rd_t;
  // pin pattern to command
  function automatic sdcp_cmd_t sdcp_decode(input sdcp_ctl_t ctl);
    sdcp_cmd_t c;
    c = CMD_DESEL;
    if (!ctl.cs_n)
    begin
      unique case ({ctl.ras_n, ctl.cas_n, ctl.we_n})
        `SDCP_PAT_NOP: c = CMD_NOP;
        `SDCP_PAT_ACT: c = CMD_ACT;
        `SDCP_PAT_READ: c = CMD_READ;
        `SDCP_PAT_WRITE: c = CMD_WRITE;
        `SDCP_PAT_BST: c = CMD_BST;
        `SDCP_PAT_PRE: c = CMD_PRE;
        `SDCP_PAT_REF: c = CMD_REF;
        `SDCP_PAT_MRS: c = CMD_MRS;
      endcase
    end
    return c;
  endfunction
endpackage

// ===== design/sdcp_bank.sv
// one bank's row state: open flag and open row address
// assumes activate and close strobes are already decoded for this bank
`timescale 1ns/1ps
`default_nettype none
module sdcp_bank
  import sdcp_pkg::*;
#(
  parameter int ROW_W = 12
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // strobes for this bank
  input wire logic act_i,
  input wire logic pre_i,
  input wire logic [ROW_W-1:0] row_i,
  // state
  output logic open_o,
  output logic [ROW_W-1:0] row_o
);
  logic open_r; // a row is open
  logic [ROW_W-1:0] row_r; // the open row

  // activate is tested before close, so an activate in the same edge leaves the row open
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      open_r <= 1'b0;
      row_r <= '0;
    end
    else if (act_i)
    begin
      open_r <= 1'b1;
      row_r <= row_i;
    end
    else if (pre_i)
    begin
      open_r <= 1'b0;
    end
  end

  assign open_o = open_r;
  assign row_o = row_r;
endmodule // sdcp_bank
`default_nettype wire

// ===== verification/sdcp_props.sv
// checker for the dram command layer: pin relations over time
// assumes it is bound into sdcp_top and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
module sdcp_props
#(
  parameter int ROW_W = 12,
  parameter bit AUTOMOTIVE = 1'b0
)
(
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RSTN_I,
  // command pins
  input wire logic CKE_I,
  input wire logic CS_N_I,
  input wire logic RAS_N_I,
  input wire logic CAS_N_I,
  input wire logic WE_N_I,
  input wire logic [1:0] BA_I,
  input wire logic [11:0] ADDR_I,
  input wire logic [3:0] DQM_I,
  // watched outputs
  input wire logic [3:0] DQ_OE_O,
  input wire logic [11:0] MODE_O,
  input wire logic [3:0] BANK_OPEN_O,
  input wire logic [ROW_W-1:0] REFRESH_ROW_O,
  input wire logic SELF_REF_O,
  input wire logic BURST_ACT_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);
  // a command only counts when selected, gate high and awake
  wire logic live = CKE_I && !CS_N_I && !SELF_REF_O;
  wire logic [2:0] pat = {RAS_N_I, CAS_N_I, WE_N_I};
  mode_load_a: assert property (
    live && pat == 3'h0 |=> MODE_O == $past(ADDR_I)) else $error("mode value not loaded");
  mode_keep_a: assert property (
    !(live && pat == 3'h0) |=> $stable(MODE_O)) else $error("mode changed without load");
  act_open_a: assert property (
    live && pat == 3'h3 |=> BANK_OPEN_O[$past(BA_I)]) else $error("activate did not open");
  pre_one_a: assert property (
    live && pat == 3'h2 && !ADDR_I[10] |=> !BANK_OPEN_O[$past(BA_I)]) else $error("bank open");
  pre_all_a: assert property (
    live && pat == 3'h2 && ADDR_I[10] |=> BANK_OPEN_O == 4'h0) else $error("banks still open");
  read_mask_a: assert property (
    DQM_I != 4'h0 |-> ##2 (DQ_OE_O & $past(DQM_I, 2)) == 4'h0) else $error("masked lane driven");
  burst_stop_a: assert property (
    live && pat == 3'h6 |=> !BURST_ACT_O) else $error("burst not cut");
  refresh_step_a: assert property (
    live && pat == 3'h1 |=> REFRESH_ROW_O == ROW_W'($past(REFRESH_ROW_O) + 1'b1))
    else $error("refresh row not stepped");
  self_entry_a: assert property (
    !CS_N_I && pat == 3'h1 && !CKE_I && !SELF_REF_O && !AUTOMOTIVE |=> SELF_REF_O)
    else $error("self refresh not entered");
  self_stay_a: assert property (
    SELF_REF_O && !CKE_I |=> SELF_REF_O && $stable(MODE_O) && $stable(BANK_OPEN_O))
    else $error("self refresh disturbed");
  self_exit_a: assert property (
    SELF_REF_O && CKE_I |=> !SELF_REF_O) else $error("self refresh not left");
  // main scenarios reached
  cover property (live && pat == 3'h4);
  cover property (DQ_OE_O != 4'h0);
  cover property (SELF_REF_O ##1 !SELF_REF_O);
endmodule // sdcp_props
bind sdcp_top sdcp_props #(.ROW_W(ROW_W), .AUTOMOTIVE(AUTOMOTIVE)) i_props (
  .CLK_SYS_I(CLK_SYS_I), .RSTN_I(RSTN_I), .CKE_I(CKE_I), .CS_N_I(CS_N_I),
  .RAS_N_I(RAS_N_I), .CAS_N_I(CAS_N_I), .WE_N_I(WE_N_I), .BA_I(BA_I), .ADDR_I(ADDR_I),
  .DQM_I(DQM_I), .DQ_OE_O(DQ_OE_O), .MODE_O(MODE_O), .BANK_OPEN_O(BANK_OPEN_O),
  .REFRESH_ROW_O(REFRESH_ROW_O), .SELF_REF_O(SELF_REF_O), .BURST_ACT_O(BURST_ACT_O));
`default_nettype wire

// ===== verification/sdcp_ctl_model.sv
// controller model: drives command, address, mask and write data pins
// assumes one cmd call per clock; pins change just after each rising edge
`timescale 1ns/1ps
`default_nettype none
module sdcp_ctl_model
  import sdcp_pkg::*;
#(
  parameter int WAIT_N = 2 // mode load, precharge and exit waits in clocks
)
(
  // clock
  input wire logic clk_i,
  // command pins
  output logic cke_o,
  output sdcp_ctl_t ctl_o,
  output logic [1:0] ba_o,
  output logic [11:0] addr_o,
  output logic [3:0] dqm_o,
  // write data
  output logic [31:0] dq_o
);
  // idle pins: selected no-op with the clock gate high
  initial
  begin
    cke_o = 1'b1;
    ctl_o = 4'h7;
    ba_o = 2'h0;
    addr_o = 12'h000;
    dqm_o = 4'hf;
    dq_o = 32'h0;
  end
  // one command per edge; data lines toggle when not carrying write data,
  // so a stale word can never pass for a fresh one
  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
                     input logic [3:0] m, input logic [31:0] d, input logic dv, input logic ck);
    @(posedge clk_i);
    cke_o <= ck;
    ctl_o <= c;
    ba_o <= b;
    addr_o <= a;
    dqm_o <= m;
    dq_o <= dv ? d : ~dq_o;
    // quiet no-ops after mode load, precharge and self refresh exit
    if (c == 4'h0 || c == 4'h2 || (ck && !cke_o))
    begin
      repeat (WAIT_N)
      begin
        @(posedge clk_i);
        ctl_o <= 4'h7;
        dq_o <= ~dq_o;
      end
    end
  endtask
endmodule // sdcp_ctl_model
`default_nettype wire

// ===== verification/sdcp_top_bench.sv
// self-checking bench for the dram command layer with a controller model
// assumes a 20 MHz clock and a small memory: two row bits, three column bits
`timescale 1ns/1ps
`default_nettype none
module sdcp_top_bench;
  // pins between model and design
  logic clk = 1'b0;
  logic rstn = 1'b0;
  wire logic cke;
  wire sdcp_pkg::sdcp_ctl_t ctl;
  wire logic [1:0] ba;
  wire logic [11:0] addr;
  wire logic [3:0] dqm;
  wire logic [31:0] dq_in;
  wire logic [31:0] dq_out;
  wire logic [3:0] oe;
  wire logic [11:0] mode;
  wire logic [3:0] bopen;
  wire logic [1:0] rrow;
  wire logic selfr;
  wire logic bact;
  wire logic selfr_auto; // self refresh flag of the automotive variant
  // expected state: memory, open rows, mode, refresh row, random source
  logic [31:0] mem [0:3][0:3][0:7];
  logic [1:0] orow [0:3];
  logic [11:0] mode_m;
  logic [1:0] rr_m = 2'h0;
  logic [31:0] seed = 32'h0001435f;
  int n_checks = 0;
  int error_cnt = 0;
  sdcp_ctl_model i_ctl (.clk_i(clk), .cke_o(cke), .ctl_o(ctl), .ba_o(ba), .addr_o(addr),
    .dqm_o(dqm), .dq_o(dq_in));
  sdcp_top #(.ROW_W(2), .COL_W(3), .CAS_LAT(2), .BURST_LEN(4), .AUTOMOTIVE(1'b0)) i_dut (
    .CLK_SYS_I(clk), .RSTN_I(rstn), .CKE_I(cke), .CS_N_I(ctl.cs_n), .RAS_N_I(ctl.ras_n),
    .CAS_N_I(ctl.cas_n), .WE_N_I(ctl.we_n), .BA_I(ba), .ADDR_I(addr), .DQM_I(dqm),
    .DQ_I(dq_in), .DQ_O(dq_out), .DQ_OE_O(oe), .MODE_O(mode), .BANK_OPEN_O(bopen),
    .REFRESH_ROW_O(rrow), .SELF_REF_O(selfr), .BURST_ACT_O(bact));
  // automotive variant on the same pins: the self refresh entry must be ignored
  sdcp_top #(.ROW_W(2), .COL_W(3), .CAS_LAT(2), .BURST_LEN(4), .AUTOMOTIVE(1'b1)) i_dut_auto (
    .CLK_SYS_I(clk), .RSTN_I(rstn), .CKE_I(cke), .CS_N_I(ctl.cs_n), .RAS_N_I(ctl.ras_n),
    .CAS_N_I(ctl.cas_n), .WE_N_I(ctl.we_n), .BA_I(ba), .ADDR_I(addr), .DQM_I(dqm),
    .DQ_I(dq_in), .DQ_O(), .DQ_OE_O(), .MODE_O(), .BANK_OPEN_O(), .REFRESH_ROW_O(),
    .SELF_REF_O(selfr_auto), .BURST_ACT_O());
  // 50 ns clock
  initial
  begin
    forever #25 clk = ~clk;
  end
  // next value of the random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // byte lanes that pass, spread over the data word
  function automatic logic [31:0] lanes(input logic [3:0] p);
    return {{8{p[3]}}, {8{p[2]}}, {8{p[1]}}, {8{p[0]}}};
  endfunction
  // compare one value and count it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t %s: got %h, expected %h", $time, what, got, exp);
    end
  endtask
  // plain command without mask or data
  task automatic c(input logic [3:0] k, input logic [1:0] b, input logic [11:0] a, input logic ck);
    i_ctl.cmd(k, b, a, 4'h0, 32'h0, 1'b0, ck);
  endtask
  // four beat write, masks random when msk is set
  task automatic wr(input logic [1:0] b, input logic [2:0] col, input logic ap, input logic msk);
    logic [3:0] m;
    logic [2:0] cc;
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      m = msk ? seed[7:4] : 4'h0;
      cc = col + i[2:0];
      mem[b][orow[b]][cc] = (mem[b][orow[b]][cc] & lanes(m)) | (seed & lanes(~m));
      i_ctl.cmd(i == 0 ? 4'h4 : 4'h7, b, {1'b0, ap, 7'h00, col}, m, seed, 1'b1, 1'b1);
    end
    c(4'h7, 2'h0, 12'h000, 1'b1);
    #1;
    chk({31'h0, bopen[b]}, {31'h0, !ap}, "write auto close");
  endtask
  // four beat read with random masks; words checked as they land
  task automatic rd(input logic [1:0] b, input logic [2:0] col, input logic ap);
    logic [3:0] m [0:7];
    logic [31:0] e;
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      m[i] = (i < 4) ? seed[3:0] : 4'hf;
    end
    i_ctl.cmd(4'h5, b, {1'b0, ap, 7'h00, col}, m[0], 32'h0, 1'b0, 1'b1);
    for (int j = 0; j < 6; j++)
    begin
      i_ctl.cmd(4'h7, 2'h0, 12'h000, m[j + 1], 32'h0, 1'b0, 1'b1);
      #1;
      if (j >= 1 && j <= 4)
      begin
        e = mem[b][orow[b]][col + 3'(j - 1)];
        chk({28'h0, oe}, {28'h0, ~m[j - 1]}, "read lane enables");
        chk(dq_out & lanes(~m[j - 1]), e & lanes(~m[j - 1]), "read data");
      end
      if (j == 3)
        chk({30'h0, bact, bopen[b]}, {30'h0, 1'b0, !ap}, "burst end, auto close");
    end
    chk({28'h0, oe}, 32'h0, "lanes released");
  endtask
  // one line as each test ends
  task automatic done_test(input string n);
    $display("test %s ended, %0d checks so far", n, n_checks);
  endtask
  // verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // a hang counts as a mismatch
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    tally_and_finish;
  end
  // main sequence
  initial
  begin
    logic [2:0] col;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    c(4'h7, 2'h0, 12'h000, 1'b1);
    #1;
    chk({12'h0, mode, bopen, rrow, selfr, bact}, 32'h0, "reset state");
    // deselected and gated commands do nothing
    seed = lfsr(seed);
    mode_m = seed[11:0];
    c(4'h8, 2'h0, ~mode_m, 1'b1);
    c(4'hb, 2'h0, 12'h000, 1'b1);
    c(4'h0, 2'h0, ~mode_m, 1'b0);
    c(4'h7, 2'h0, 12'h000, 1'b1);
    #1;
    chk({16'h0, mode, bopen}, 32'h0, "ignored commands");
    c(4'h0, seed[13:12], mode_m, 1'b1);
    #1;
    chk({20'h0, mode}, {20'h0, mode_m}, "mode value");
    done_test("mode");
    // open one row in every idle bank
    for (int b = 0; b < 4; b++)
    begin
      seed = lfsr(seed);
      orow[b] = seed[1:0];
      c(4'h3, 2'(b), {10'h000, orow[b]}, 1'b1);
    end
    c(4'h7, 2'h0, 12'h000, 1'b1);
    #1;
    chk({28'h0, bopen}, 32'h0000000f, "all banks open");
    // full write, masked write, masked read; last bank wraps the page
    for (int b = 0; b < 4; b++)
    begin
      seed = lfsr(seed);
      col = (b == 3) ? 3'h7 : seed[2:0];
      wr(2'(b), col, 1'b0, 1'b0);
      wr(2'(b), col, 1'b0, 1'b1);
      rd(2'(b), col, 1'b0);
    end
    done_test("data");
    // burst terminate right after a read
    c(4'h5, 2'h1, 12'h000, 1'b1);
    c(4'h6, 2'h0, 12'h000, 1'b1);
    c(4'h7, 2'h0, 12'h000, 1'b1);
    #1;
    chk({31'h0, bact}, 32'h0, "burst cut");
    repeat (3) c(4'h7, 2'h0, 12'h000, 1'b1);
    // closing rows: one bank, auto close on read and write, then all
    c(4'h2, 2'h1, 12'h000, 1'b1);
    #1;
    chk({28'h0, bopen}, 32'h0000000d, "one bank closed");
    // fill the columns first so the auto close read sees known words
    wr(2'h0, 3'h0, 1'b0, 1'b0);
    rd(2'h0, 3'h0, 1'b1);
    wr(2'h2, 3'h0, 1'b1, 1'b1);
    c(4'h2, 2'h1, 12'h400, 1'b1);
    #1;
    chk({28'h0, bopen}, 32'h0, "all banks closed");
    done_test("close");
    // back to back auto refresh with random address
    seed = lfsr(seed);
    c(4'h1, 2'h3, seed[11:0], 1'b1);
    c(4'h1, 2'h2, seed[23:12], 1'b1);
    c(4'h7, 2'h0, 12'h000, 1'b1);
    rr_m = rr_m + 2'h2;
    #1;
    chk({30'h0, rrow}, {30'h0, rr_m}, "refresh row");
    // self refresh: entry, ignored load, internal step, exit, resume
    c(4'h1, 2'h0, 12'h000, 1'b0);
    c(4'h0, 2'h0, ~mode_m, 1'b0);
    #1;
    chk({31'h0, selfr}, 32'h1, "self refresh entered");
    chk({31'h0, selfr_auto}, 32'h0, "automotive entry ignored");
    repeat (320) c(4'h7, 2'h0, 12'h000, 1'b0);
    rr_m = rr_m + 2'h1;
    c(4'h7, 2'h0, 12'h000, 1'b1);
    #1;
    chk({17'h0, selfr, rrow, mode}, {17'h0, 1'b0, rr_m, mode_m}, "self refresh stay");
    c(4'h1, 2'h0, 12'h000, 1'b1);
    c(4'h7, 2'h0, 12'h000, 1'b1);
    #1;
    chk({30'h0, rrow}, {30'h0, rr_m + 2'h1}, "refresh resumed");
    done_test("refresh");
    tally_and_finish;
  end
endmodule // sdcp_top_bench
`default_nettype wire
